// File: logic/bsm_cfg_if.sv
// carries the resolved boot path between decoder and pin claim/power sense logic
`timescale 1ns/1ps
interface bsm_cfg_if;
   import bsm_pkg::*;
   bsm_mode_e mode;
   logic done;
   modport src (output mode, output done);
   modport dst (input mode, input done);
endinterface : bsm_cfg_if

// File: logic/bsm_consts.svh
// constants for the boot strap mode select block
`ifndef BSM_CONSTS_SVH
`define BSM_CONSTS_SVH
// register offsets (byte addresses)
`define BSM_OFS_MODE 8'h00
`define BSM_OFS_RAMCTL 8'h04
`define BSM_OFS_PINS 8'h08
`define BSM_OFS_RAMMAP 8'h0C
// ram control field positions
`define BSM_RAM_MID_BIT 0
`define BSM_RAM_TOP_BIT 1
// reset values
`define BSM_RAMCTL_RST 2'h3
// ram layout
`define BSM_RAM_BASE 32'h0200_0000
`define BSM_RAM_LOW_KB 16
`define BSM_RAM_TOP_KB 4
// timing: cycles after reset release before straps are taken
`define BSM_SETTLE_CYC 4
`define BSM_MAX_BOOT_PINS 4
`endif

// File: logic/bsm_pin_claim.sv
// pin claim for the chosen programming interface
`timescale 1ns/1ps
`include "bsm_consts.svh"
module bsm_pin_claim (
   input wire logic clk, // system clock
   input wire logic resetn, // async reset, active low
   bsm_cfg_if.dst cfg, // resolved mode in
   output logic [5:0] claim // serial tx,rx, can tx,rx, usb sense, straps
);
   import bsm_pkg::*;
   logic [5:0] claim_reg, claim_next;

   // only pins of the chosen port are claimed
   always_comb begin
      claim_next = 6'h00; // others stay free
      if (cfg.done) begin
         unique case (cfg.mode)
            bsm_mode_serial: claim_next = 6'h03;
            bsm_mode_can: claim_next = 6'h0C;
            bsm_mode_usb, bsm_mode_usb_fallback: claim_next = 6'h10;
            default: claim_next = 6'h00;
         endcase
      end
   end

   // claim register
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         claim_reg <= 6'h00;
      end else begin
         claim_reg <= claim_next;
      end
   end

   assign claim = claim_reg;
endmodule : bsm_pin_claim

// File: logic/bsm_pkg.sv
// types of the boot strap mode select block
package bsm_pkg;
   typedef enum logic [2:0] {
      bsm_mode_flash,
      bsm_mode_can,
      bsm_mode_usb,
      bsm_mode_serial,
      bsm_mode_usb_fallback
   } bsm_mode_e;
   typedef enum logic [1:0] {
      bsm_st_settle,
      bsm_st_decode,
      bsm_st_wait_code,
      bsm_st_done
   } bsm_state_e;
endpackage : bsm_pkg

// File: logic/bsm_strap_decode.sv
// strap sampling and boot path decode
`timescale 1ns/1ps
`include "bsm_consts.svh"
module bsm_strap_decode #(
   parameter int SETTLE = `BSM_SETTLE_CYC
) (
   input wire logic clk, // system clock
   input wire logic resetn, // async reset, active low
   input wire logic boot_strap_a, // first strap level
   input wire logic boot_strap_b, // second strap level
   input wire logic code_check_done, // flash code check finished
   input wire logic code_valid, // flash code check result
   bsm_cfg_if.src cfg // resolved mode out
);
   import bsm_pkg::*;
   bsm_state_e state_reg, state_next;
   bsm_mode_e mode_reg, mode_next;
   logic [7:0] cnt_reg, cnt_next;
   logic done_reg, done_next;

   // next state of the decoder
   always_comb begin
      state_next = state_reg;
      mode_next = mode_reg;
      cnt_next = cnt_reg;
      done_next = done_reg;
      unique case (state_reg)
         bsm_st_settle: begin
            cnt_next = cnt_reg + 8'h01;
            if (cnt_reg == 8'(SETTLE - 1)) begin
               state_next = bsm_st_decode;
            end
         end
         bsm_st_decode: begin
            // straps read once
            unique case ({boot_strap_a, boot_strap_b})
               2'h3: begin
                  mode_next = bsm_mode_flash;
                  state_next = bsm_st_wait_code;
               end
               2'h2: begin
                  mode_next = bsm_mode_can;
                  state_next = bsm_st_done;
               end
               2'h1: begin
                  mode_next = bsm_mode_usb;
                  state_next = bsm_st_done;
               end
               default: begin
                  mode_next = bsm_mode_serial;
                  state_next = bsm_st_done;
               end
            endcase
         end
         bsm_st_wait_code: begin
            if (code_check_done) begin
               if (!code_valid) begin
                  mode_next = bsm_mode_usb_fallback;
               end
               state_next = bsm_st_done;
            end
         end
         bsm_st_done: begin
            done_next = 1'b1; // held, straps no longer looked at
         end
      endcase
   end

   // decoder registers
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         state_reg <= bsm_st_settle;
         mode_reg <= bsm_mode_flash;
         cnt_reg <= 8'h00;
         done_reg <= 1'b0;
      end else begin
         state_reg <= state_next;
         mode_reg <= mode_next;
         cnt_reg <= cnt_next;
         done_reg <= done_next;
      end
   end

   assign cfg.mode = mode_reg;
   assign cfg.done = done_reg;
endmodule : bsm_strap_decode

// File: logic/bsm_top.sv
// boot strap mode select: strap decode, pin claim, ram bank enables
`timescale 1ns/1ps
`include "bsm_consts.svh"
module bsm_top #(
   parameter int BANK_KB = `BSM_RAM_LOW_KB,
   parameter int SETTLE = `BSM_SETTLE_CYC
) (
   input wire logic clk, // system clock
   input wire logic resetn, // async reset, active low
   input wire logic boot_strap_a, // first strap pin
   input wire logic boot_strap_b, // second strap, also bus power sense
   input wire logic code_check_done, // flash code check finished
   input wire logic code_valid, // flash code is valid
   input wire logic [7:0] addr, // register address
   input wire logic [31:0] wdata, // write data
   input wire logic wr, // write strobe
   input wire logic rd, // read strobe
   output logic [31:0] rdata, // read data, cycle after rd
   output logic boot_done, // boot path resolved
   output logic [2:0] boot_mode, // resolved mode code
   output logic [5:0] pin_claim, // pins held by boot port
   output logic bus_power_sense, // usb power sense level
   output logic [2:0] ram_bank_en // low, mid, top enables
);
   import bsm_pkg::*;

   // ------------------------------------------------------------
   // decode and pin claim
   // ------------------------------------------------------------
   bsm_cfg_if cfg ();
   logic [5:0] claim;

   bsm_strap_decode #(.SETTLE(SETTLE)) u_dec (
      .clk(clk),
      .resetn(resetn),
      .boot_strap_a(boot_strap_a),
      .boot_strap_b(boot_strap_b),
      .code_check_done(code_check_done),
      .code_valid(code_valid),
      .cfg(cfg.src)
   );

   bsm_pin_claim u_pin (
      .clk(clk),
      .resetn(resetn),
      .cfg(cfg.dst),
      .claim(claim)
   );

   // ------------------------------------------------------------
   // registers
   // ------------------------------------------------------------
   logic [1:0] ramctl_reg, ramctl_next;
   logic [31:0] rdata_reg, rdata_next;
   logic [2:0] bank_reg, bank_next;
   logic [5:0] claim_out_reg;
   logic done_reg;
   logic [2:0] mode_reg;
   logic sense_reg, sense_next;
   logic [3:0] pin_count;

   // reserved pins: two straps plus the serial or can port pins (claim bits 0 to 3, usb sense not counted)
   always_comb begin
      pin_count = 4'h2;
      for (int i = 0; i < 4; i++) begin
         pin_count = pin_count + {3'h0, claim[i]};
      end
   end

   // software bank control and read mux
   always_comb begin
      ramctl_next = ramctl_reg;
      if (wr && addr == `BSM_OFS_RAMCTL) begin
         ramctl_next = wdata[1:0];
      end
      rdata_next = 32'h0000_0000;
      if (rd) begin
         unique case (addr)
            `BSM_OFS_MODE: rdata_next = {20'h00000, pin_count, 3'h0, done_reg, 1'b0, mode_reg};
            `BSM_OFS_RAMCTL: rdata_next = {30'h0, ramctl_reg};
            `BSM_OFS_PINS: rdata_next = {26'h0, claim_out_reg};
            `BSM_OFS_RAMMAP: rdata_next = `BSM_RAM_BASE;
            default: rdata_next = 32'h0000_0000;
         endcase
      end
      // low bank fixed on; upper banks follow control
      bank_next = {ramctl_reg[`BSM_RAM_TOP_BIT], ramctl_reg[`BSM_RAM_MID_BIT], 1'b1};
      // sense shares strap b once in usb mode
      sense_next = (cfg.done && (cfg.mode == bsm_mode_usb || cfg.mode == bsm_mode_usb_fallback))
         ? boot_strap_b : 1'b0;
   end

   // register stage for all outputs
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         ramctl_reg <= `BSM_RAMCTL_RST;
         rdata_reg <= 32'h0000_0000;
         bank_reg <= 3'h1;
         claim_out_reg <= 6'h00;
         done_reg <= 1'b0;
         mode_reg <= 3'h0;
         sense_reg <= 1'b0;
      end else begin
         ramctl_reg <= ramctl_next;
         rdata_reg <= rdata_next;
         bank_reg <= bank_next;
         claim_out_reg <= claim;
         done_reg <= cfg.done;
         mode_reg <= cfg.mode;
         sense_reg <= sense_next;
      end
   end

   assign rdata = rdata_reg;
   assign boot_done = done_reg;
   assign boot_mode = mode_reg;
   assign pin_claim = claim_out_reg;
   assign bus_power_sense = sense_reg;
   assign ram_bank_en = bank_reg;
endmodule : bsm_top

// File: verification/bsm_assertions.sv
// assertions for the boot strap mode select block
`timescale 1ns/1ps
module bsm_checker #(parameter int BANK_KB = 16, parameter int SETTLE = 4) (
   input wire logic clk, // clock
   input wire logic resetn, // reset
   input wire logic code_check_done, // check end
   input wire logic code_valid, // check result
   input wire logic [7:0] addr, // address
   input wire logic [31:0] wdata, // write data
   input wire logic wr, // write strobe
   input wire logic boot_done, // resolved
   input wire logic [2:0] boot_mode, // mode
   input wire logic [5:0] pin_claim, // claims
   input wire logic [2:0] ram_bank_en // banks
);
   // ------
   // properties
   // ------
   logic [3:0] rel_reg, rel_next; // edges since release
   // saturating edge count
   always_comb rel_next = (rel_reg == 4'hF) ? rel_reg : rel_reg + 4'h1;
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) rel_reg <= 4'h0;
      else rel_reg <= rel_next;
   end
   default clocking @(posedge clk); endclocking
   default disable iff (!resetn);
   property p_low_on; ram_bank_en[0]; endproperty
   a_low_on: assert property (p_low_on) else $error("low bank off");
   property p_hold; boot_done |=> boot_done && $stable(boot_mode); endproperty
   a_hold: assert property (p_hold) else $error("mode moved");
   property p_early; rel_reg < SETTLE |-> !boot_done; endproperty
   a_early: assert property (p_early) else $error("early done");
   property p_flash; boot_done && boot_mode == 3'h0 |-> code_check_done && code_valid; endproperty
   a_flash: assert property (p_flash) else $error("bad flash boot");
   property p_fall; boot_done && boot_mode == 3'h4 |-> code_check_done && !code_valid; endproperty
   a_fall: assert property (p_fall) else $error("bad fallback");
   property p_can; boot_done && boot_mode == 3'h1 |=> pin_claim == 6'h0C; endproperty
   a_can: assert property (p_can) else $error("can pins wrong");
   property p_ser; boot_done && boot_mode == 3'h3 |=> pin_claim == 6'h03; endproperty
   a_ser: assert property (p_ser) else $error("serial pins wrong");
   property p_ram; wr && addr == 8'h04 |-> ##2 ram_bank_en[2:1] == $past(wdata[1:0], 2); endproperty
   a_ram: assert property (p_ram) else $error("bank enable wrong");
   c_fall: cover property (boot_done && boot_mode == 3'h4);
   c_ser: cover property (boot_done && boot_mode == 3'h3);
   c_ram: cover property (wr && addr == 8'h04);
endmodule : bsm_checker
bind bsm_top bsm_checker #(.BANK_KB(BANK_KB), .SETTLE(SETTLE)) chk_u (.clk, .resetn,
   .code_check_done, .code_valid, .addr, .wdata, .wr, .boot_done, .boot_mode, .pin_claim,
   .ram_bank_en);

// File: verification/bsm_board.sv
// board straps and flash check source
`timescale 1ns/1ps
module bsm_board #(parameter int CHECK_CYC = 12) (
   input wire logic clk, // clock
   input wire logic resetn, // reset
   input wire logic [1:0] sel, // strap levels a,b
   input wire logic good, // flash code good
   output logic boot_strap_a, // strap a
   output logic boot_strap_b, // strap b and power sense
   output logic code_check_done, // check end
   output logic code_valid // result, wrong until done
);
   int cnt;
   // straps follow sel directly, b doubles as power sense
   assign boot_strap_a = sel[1];
   assign boot_strap_b = sel[0];
   // slow flash check
   always @(posedge clk or negedge resetn) begin
      if (!resetn) cnt <= 0;
      else if (cnt < CHECK_CYC) cnt <= cnt + 1;
   end
   assign code_check_done = (cnt == CHECK_CYC);
   assign code_valid = code_check_done ? good : ~good;
endmodule : bsm_board

// File: verification/testbench.sv
// self-checking bench of the boot strap mode select block
`timescale 1ns/1ps
module testbench;
   typedef struct {logic [1:0] s; logic g; logic [2:0] m; logic [4:0] c;} bsm_row_s;
   logic clk = 1'h0, resetn = 1'h0, wr = 1'h0, rd = 1'h0, good = 1'h1;
   logic [1:0] sel = 2'h3;
   logic [7:0] addr = 8'h00;
   logic [31:0] wdata = 32'h0, rdata, d;
   logic boot_strap_a, boot_strap_b, code_check_done, code_valid, boot_done, bus_power_sense;
   logic [2:0] boot_mode, ram_bank_en;
   logic [5:0] pin_claim;
   int n_errors = 0, n_checks = 0;
   // flash ok, flash bad, can, usb, serial
   bsm_row_s rows[5] = '{'{2'h3, 1'h1, 3'h0, 5'h00}, '{2'h3, 1'h0, 3'h4, 5'h10},
      '{2'h2, 1'h1, 3'h1, 5'h0C}, '{2'h1, 1'h1, 3'h2, 5'h10}, '{2'h0, 1'h1, 3'h3, 5'h03}};
   always #10 clk = ~clk;
   bsm_board board_u (.clk, .resetn, .sel, .good, .boot_strap_a, .boot_strap_b,
      .code_check_done, .code_valid);
   bsm_top dut_u (.clk, .resetn, .boot_strap_a, .boot_strap_b, .code_check_done, .code_valid,
      .addr, .wdata, .wr, .rd, .rdata, .boot_done, .boot_mode, .pin_claim, .bus_power_sense,
      .ram_bank_en);
   // ------
   // tasks
   // ------
   task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
      n_checks++;
      if (got !== exp) begin
         n_errors++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : cmp
   task automatic print_verdict;
      $display("checks=%0d errors=%0d", n_checks, n_errors);
      if (n_errors == 0 && n_checks > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask : print_verdict
   task automatic wr_reg(input logic [7:0] a, input logic [31:0] v);
      @(posedge clk);
      addr <= a;
      wdata <= v;
      wr <= 1'h1;
      @(posedge clk);
      wr <= 1'h0;
   endtask : wr_reg
   task automatic rd_reg(input logic [7:0] a);
      @(posedge clk);
      addr <= a;
      rd <= 1'h1;
      @(posedge clk);
      rd <= 1'h0;
      #1 d = rdata;
   endtask : rd_reg
   task automatic boot(input logic [1:0] s, input logic g);
      resetn <= 1'h0;
      sel <= s;
      good <= g;
      repeat (5) @(posedge clk);
      resetn <= 1'h1;
      for (int i = 0; i < 40 && boot_done !== 1'h1; i++) begin
         @(posedge clk);
         #1;
      end
      if (boot_done !== 1'h1) begin
         n_errors++;
         print_verdict();
      end
      // pin claim shows one cycle after done
      @(posedge clk);
      #1;
   endtask : boot
   // rows, then reset and register cases
   initial begin
      foreach (rows[i]) begin
         boot(rows[i].s, rows[i].g);
         cmp({29'h0, boot_mode}, {29'h0, rows[i].m});
         cmp({26'h0, pin_claim}, {27'h0, rows[i].c});
         cmp({31'h0, bus_power_sense},
            {31'h0, rows[i].m == 3'h2 || rows[i].m == 3'h4});
         rd_reg(8'h00);
         cmp({27'h0, d[4:0]}, {27'h0, 2'h2, rows[i].m});
         cmp({31'h0, d[11:8] <= 4'h4}, 32'h1);
         @(posedge clk);
         sel <= ~rows[i].s;
         repeat (3) @(posedge clk);
         #1 cmp({29'h0, boot_mode}, {29'h0, rows[i].m});
      end
      @(posedge clk);
      resetn <= 1'h0;
      #15 cmp({28'h0, boot_done, ram_bank_en}, 32'h1);
      boot(2'h0, 1'h1);
      cmp({29'h0, ram_bank_en}, 32'h7);
      wr_reg(8'h04, 32'h0);
      wr_reg(8'h04, 32'h2);
      repeat (2) @(posedge clk);
      #1 cmp({29'h0, ram_bank_en}, 32'h5);
      wr_reg(8'h04, 32'hFFFFFFFF);
      rd_reg(8'h04);
      cmp(d, 32'h3);
      wr_reg(8'h00, 32'hFFFFFFFF);
      rd_reg(8'h00);
      cmp({27'h0, d[4:0]}, 32'h13);
      rd_reg(8'h0C);
      cmp(d, 32'h02000000);
      rd_reg(8'h08);
      cmp(d, 32'h3);
      rd_reg(8'h10);
      cmp(d, 32'h0);
      print_verdict();
   end
endmodule : testbench
